// *** hdl/mae_pkg.sv ***
/*
  Shared constants and types for the arithmetic and logic execution unit.
  Assumes a decoder upstream that hands over one decoded instruction at a time.
*/
package mae_pkg;

  // Data and address widths
  localparam int DW = 8;
  localparam int AW = 16;

  // Operations carried out by the unit
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INC, OP_STEP_DOWN, OP_INC_DP,
    OP_TIMES_OP, OP_DIV, OP_DECIMAL_ADJUST, OP_BITWISE_AND, OP_BITWISE_OR, OP_BITWISE_XOR,
    OP_ZERO_ACC, OP_INVERT_ACC, OP_ROTATE_LEFT, OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT,
    OP_ROTATE_RIGHT_THROUGH_CARRY, OP_SWAP, OP_CODE_RD, OP_BIT_RD
  } mae_op_t;

  // Operand addressing modes
  typedef enum logic [3:0] {
    AM_REG, AM_DIR, AM_IND, AM_IMM, AM_ACC, AM_DIR_A, AM_DIR_IMM, AM_IND_DP, AM_IDX, AM_BIT
  } mae_mode_t;

  // Address space driven on the memory port
  typedef enum logic [1:0] {SP_IRAM, SP_XRAM, SP_CODE} mae_space_t;

  // One decoded instruction
  typedef struct packed {
    mae_op_t   op;
    mae_mode_t mode;
    logic [2:0] ridx;
    logic [7:0] arg1;
    logic [7:0] arg2;
  } mae_instr_t;

  // Program status flags
  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } mae_flags_t;

  // Load port into the working register banks
  typedef struct packed {
    logic       we;
    logic [4:0] idx;
    logic [7:0] data;
  } mae_regwr_t;

  // Reset values
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [15:0] DP_RST  = 16'h0000;

  // Bit space layout: low half in RAM bytes from this base, high half in registers at addresses that are multiples of eight
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_MASK = 8'hf8;
  localparam logic [1:0] PTR_HI       = 2'h0;

  // Decimal adjust constants
  localparam logic [3:0] DA_NIB_MAX = 4'h9;
  localparam logic [8:0] DA_LO_ADJ  = 9'h006;
  localparam logic [8:0] DA_HI_ADJ  = 9'h060;

  // Cycle counts and byte lengths
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FIVE  = 3'h5;
  localparam logic [2:0] CYC_SIX   = 3'h6;
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

endpackage

// *** hdl/mae_exec.sv ***
/*
  Arithmetic and logic execution unit of an 8-bit core: accumulator, B, flags,
  data pointer, four banks of eight working registers and the memory operand port.
  Assumes the memory answers on mem_rd_i in the cycle its address is presented.
*/
// Functional notes
// - Direct mode uses the 8-bit instruction address, internal RAM and registers only.
// - Indirect mode takes an 8-bit address from a pointer register or 16-bit pointer.
// - Register mode picks one of eight registers in the selected bank.
// - Indexed mode only reads program memory at data pointer plus accumulator.
// - Bit mode picks one bit out of 256 addressable bits.
// - Immediate operands come straight from the instruction bytes.
// - Register-specific forms act on the implied accumulator.
// - Add, add with carry, subtract: 1/1, 2/2, 1/2, 2/2 bytes/cycles.
// - Subtract takes source and borrow off the accumulator.
// - Increment/decrement: acc 1, reg 2, direct 3, indirect 3 cycles; pointer 1.
// - Multiply accumulator by B: one byte, two cycles.
// - Divide takes six cycles, decimal adjust three; both one byte.
// - AND, OR, XOR act independently on each bit.
// - Logic into accumulator: same byte and cycle figures as the adds.
// - Logic into direct byte: three cycles; acc source 2 bytes, immediate 3.
// - Rotates, clear and complement of the accumulator take one cycle.
// - Nibble swap of the accumulator in one cycle.
// - Core held in reset while the reset pin is low; pin pulled up.
`timescale 1ns/1ns
module mae_exec (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 external_reset_pin_n_i,
  input  wire logic                 start_i,
  input  wire mae_pkg::mae_instr_t  instr_i,
  input  wire logic [1:0]           bank_sel_i,
  input  wire mae_pkg::mae_regwr_t  regwr_i,
  input  wire logic [7:0]           mem_rd_i,
  output logic [15:0]               mem_addr_o,
  output mae_pkg::mae_space_t       mem_space_o,
  output logic                      mem_re_o,
  output logic                      mem_we_o,
  output logic [7:0]                mem_wdata_o,
  output logic [7:0]                acc_o,
  output logic [7:0]                b_o,
  output mae_pkg::mae_flags_t       flags_o,
  output logic [15:0]               data_pointer_o,
  output logic                      bit_o,
  output logic                      busy_o,
  output logic                      done_o,
  output logic [1:0]                len_o
);
  import mae_pkg::*;

  logic              rst_c;
  logic [7:0]        regs_q [32];
  mae_instr_t        ins_q;
  logic [1:0]        bank_q;
  logic [2:0]        cnt_q;
  logic              first_q;
  logic [7:0]        opnd_q;
  logic              take;
  logic              commit;
  logic [7:0]        rval;
  logic [7:0]        src;
  logic [7:0]        tgt;
  logic [7:0]        acc_d;
  logic [7:0]        b_d;
  mae_flags_t        fl_d;
  logic [7:0]        res;
  logic              mem_wr;
  logic              reg_wr;
  logic [15:0]       addr_d;
  mae_space_t        space_d;
  logic              re_d;
  logic [8:0]        sum9;
  logic [4:0]        nib5;
  logic [7:0]        low8;
  logic [15:0]       prod;
  logic [8:0]        da9;
  logic [7:0]        bbyte;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and cycle/length tables

  // Pin low holds the core; the pull-up sits in the pad
  assign rst_c = rst_i | ~external_reset_pin_n_i;

  // Cycle count of one instruction
  function automatic logic [2:0] cyc_of(input mae_instr_t i);
    case (i.op)
      OP_INC, OP_STEP_DOWN: begin
        cyc_of = (i.mode == AM_ACC) ? CYC_ONE : (i.mode == AM_REG) ? CYC_TWO : CYC_THREE;
      end
      OP_INC_DP, OP_ZERO_ACC, OP_INVERT_ACC, OP_ROTATE_LEFT, OP_ROTATE_LEFT_THROUGH_CARRY,
      OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_THROUGH_CARRY, OP_SWAP: cyc_of = CYC_ONE;
      OP_TIMES_OP:       cyc_of = CYC_TWO;
      OP_DIV:            cyc_of = CYC_SIX;
      OP_DECIMAL_ADJUST: cyc_of = CYC_THREE;
      OP_CODE_RD:        cyc_of = CYC_FIVE;
      OP_BIT_RD:         cyc_of = CYC_TWO;
      default: begin
        cyc_of = (i.mode == AM_DIR_A || i.mode == AM_DIR_IMM) ? CYC_THREE :
                 (i.mode == AM_REG) ? CYC_ONE : CYC_TWO;
      end
    endcase
  endfunction

  // Encoded byte length of one instruction
  function automatic logic [1:0] len_of(input mae_instr_t i);
    case (i.mode)
      AM_DIR, AM_IMM, AM_DIR_A, AM_BIT: len_of = LEN_TWO;
      AM_DIR_IMM:                       len_of = LEN_THREE;
      default:                          len_of = LEN_ONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  assign take   = start_i & ~busy_o;
  assign commit = busy_o & (cnt_q == CYC_ONE);

  // Busy window of exactly the instruction's cycle count
  always_ff @(posedge clk_sys_i) begin
    if (rst_c) begin
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      cnt_q   <= CYC_ONE;
      first_q <= 1'b0;
      len_o   <= LEN_ONE;
    end else begin
      done_o  <= commit;
      first_q <= take;
      if (take) begin
        busy_o <= 1'b1;
        cnt_q  <= cyc_of(instr_i);
        len_o  <= len_of(instr_i);
      end else if (commit) begin
        busy_o <= 1'b0;
      end else if (busy_o) begin
        cnt_q <= cnt_q - CYC_ONE;
      end
    end
  end

  // Instruction latch
  always_ff @(posedge clk_sys_i) begin
    if (rst_c) begin
      ins_q  <= '0;
      bank_q <= 2'h0;
    end else if (take) begin
      ins_q  <= instr_i;
      bank_q <= bank_sel_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand address generation

  // Memory address formed from the incoming instruction
  always_comb begin
    addr_d  = 16'h0000;
    space_d = SP_IRAM;
    re_d    = 1'b1;
    bbyte   = instr_i.arg1[7] ? (instr_i.arg1 & BIT_SFR_MASK) : (BIT_RAM_BASE + {4'h0, instr_i.arg1[6:3]});
    case (instr_i.mode)
      AM_DIR, AM_DIR_A, AM_DIR_IMM: addr_d = {8'h00, instr_i.arg1};
      AM_IND:    addr_d = {8'h00, regs_q[{bank_sel_i, PTR_HI, instr_i.ridx[0]}]};
      AM_IND_DP: begin
        addr_d  = data_pointer_o;
        space_d = SP_XRAM;
      end
      AM_IDX: begin
        addr_d  = data_pointer_o + {8'h00, acc_o};
        space_d = SP_CODE;
      end
      AM_BIT:  addr_d = {8'h00, bbyte};
      default: re_d = 1'b0;
    endcase
  end

  // Memory port: address held for the instruction, write pulses at its end
  always_ff @(posedge clk_sys_i) begin
    if (rst_c) begin
      mem_addr_o  <= 16'h0000;
      mem_space_o <= SP_IRAM;
      mem_re_o    <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_we_o <= commit & mem_wr;
      if (commit) begin
        mem_wdata_o <= res;
      end
      if (take) begin
        mem_addr_o  <= addr_d;
        mem_space_o <= space_d;
        mem_re_o    <= re_d;
      end else if (first_q) begin
        mem_re_o <= 1'b0;
      end
    end
  end

  // Memory operand captured one edge after the address
  always_ff @(posedge clk_sys_i) begin
    if (rst_c) begin
      opnd_q <= 8'h00;
    end else if (first_q) begin
      opnd_q <= mem_rd_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execute

  // Operand selection and result computation
  always_comb begin
    rval   = regs_q[{bank_q, ins_q.ridx}];
    src    = (ins_q.mode == AM_REG) ? rval :
             (ins_q.mode == AM_IMM) ? ins_q.arg1 :
             (ins_q.mode == AM_DIR_IMM) ? ins_q.arg2 :
             (ins_q.mode == AM_DIR_A) ? acc_o : opnd_q;
    tgt    = (ins_q.mode == AM_REG) ? rval : (ins_q.mode == AM_ACC) ? acc_o : opnd_q;
    acc_d  = acc_o;
    b_d    = b_o;
    fl_d   = flags_o;
    res    = 8'h00;
    mem_wr = 1'b0;
    reg_wr = 1'b0;
    sum9   = 9'h000;
    nib5   = 5'h00;
    low8   = 8'h00;
    prod   = {8'h00, acc_o} * {8'h00, b_o};
    da9    = {1'b0, acc_o};
    case (ins_q.op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        sum9  = {1'b0, acc_o} + {1'b0, src} + {8'h00, (ins_q.op == OP_ADD_WITH_CARRY) & flags_o.cy};
        nib5  = {1'b0, acc_o[3:0]} + {1'b0, src[3:0]} + {4'h0, (ins_q.op == OP_ADD_WITH_CARRY) & flags_o.cy};
        low8  = {1'b0, acc_o[6:0]} + {1'b0, src[6:0]} + {7'h00, (ins_q.op == OP_ADD_WITH_CARRY) & flags_o.cy};
        acc_d = sum9[7:0];
        fl_d  = '{cy: sum9[8], ac: nib5[4], ov: sum9[8] ^ low8[7]};
      end
      OP_SUBTRACT_WITH_BORROW: begin
        sum9  = {1'b0, acc_o} - {1'b0, src} - {8'h00, flags_o.cy};
        nib5  = {1'b0, acc_o[3:0]} - {1'b0, src[3:0]} - {4'h0, flags_o.cy};
        acc_d = sum9[7:0];
        fl_d  = '{cy: sum9[8], ac: nib5[4], ov: (acc_o[7] ^ src[7]) & (acc_o[7] ^ sum9[7])};
      end
      OP_INC, OP_STEP_DOWN: begin
        res    = (ins_q.op == OP_INC) ? tgt + 8'h01 : tgt - 8'h01;
        acc_d  = (ins_q.mode == AM_ACC) ? res : acc_o;
        reg_wr = (ins_q.mode == AM_REG);
        mem_wr = (ins_q.mode == AM_DIR) || (ins_q.mode == AM_IND);
      end
      OP_TIMES_OP: begin
        acc_d   = prod[7:0];
        b_d     = prod[15:8];
        fl_d.cy = 1'b0;
        fl_d.ov = |prod[15:8];
      end
      OP_DIV: begin
        fl_d.cy = 1'b0;
        fl_d.ov = (b_o == 8'h00);
        if (b_o != 8'h00) begin
          acc_d = acc_o / b_o;
          b_d   = acc_o % b_o;
        end
      end
      OP_DECIMAL_ADJUST: begin
        if (acc_o[3:0] > DA_NIB_MAX || flags_o.ac) begin
          da9 = da9 + DA_LO_ADJ;
        end
        if (da9[7:4] > DA_NIB_MAX || flags_o.cy || da9[8]) begin
          da9 = {1'b0, da9[7:0]} + DA_HI_ADJ;
          fl_d.cy = 1'b1;
        end
        acc_d = da9[7:0];
      end
      OP_BITWISE_AND, OP_BITWISE_OR, OP_BITWISE_XOR: begin
        if (ins_q.mode == AM_DIR_A || ins_q.mode == AM_DIR_IMM) begin
          low8 = opnd_q;
        end else begin
          low8 = acc_o;
        end
        res = (ins_q.op == OP_BITWISE_AND) ? (low8 & src) :
              (ins_q.op == OP_BITWISE_OR) ? (low8 | src) : (low8 ^ src);
        mem_wr = (ins_q.mode == AM_DIR_A) || (ins_q.mode == AM_DIR_IMM);
        acc_d  = mem_wr ? acc_o : res;
      end
      OP_ZERO_ACC:      acc_d = 8'h00;
      OP_INVERT_ACC:    acc_d = ~acc_o;
      OP_ROTATE_LEFT:   acc_d = {acc_o[6:0], acc_o[7]};
      OP_ROTATE_RIGHT:  acc_d = {acc_o[0], acc_o[7:1]};
      OP_ROTATE_LEFT_THROUGH_CARRY: begin
        acc_d   = {acc_o[6:0], flags_o.cy};
        fl_d.cy = acc_o[7];
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        acc_d   = {flags_o.cy, acc_o[7:1]};
        fl_d.cy = acc_o[0];
      end
      OP_SWAP:    acc_d = {acc_o[3:0], acc_o[7:4]};
      OP_CODE_RD: acc_d = opnd_q;
      default:    acc_d = acc_o;
    endcase
  end

  // Accumulator, B and flags
  always_ff @(posedge clk_sys_i) begin
    if (rst_c) begin
      acc_o   <= ACC_RST;
      b_o     <= ACC_RST;
      flags_o <= '0;
    end else if (commit) begin
      acc_o   <= acc_d;
      b_o     <= b_d;
      flags_o <= fl_d;
    end
  end

  // Data pointer
  always_ff @(posedge clk_sys_i) begin
    if (rst_c) begin
      data_pointer_o <= DP_RST;
    end else if (commit && ins_q.op == OP_INC_DP) begin
      data_pointer_o <= data_pointer_o + 16'h0001;
    end
  end

  // Selected bit of the bit space
  always_ff @(posedge clk_sys_i) begin
    if (rst_c) begin
      bit_o <= 1'b0;
    end else if (commit && ins_q.op == OP_BIT_RD) begin
      bit_o <= opnd_q[ins_q.arg1[2:0]];
    end
  end

  // Working register banks; the core's own write wins over the load port
  always_ff @(posedge clk_sys_i) begin
    if (rst_c) begin
      for (int k = 0; k < 32; k++) begin
        regs_q[k] <= 8'h00;
      end
    end else if (commit && reg_wr) begin
      regs_q[{bank_q, ins_q.ridx}] <= res;
    end else if (regwr_i.we) begin
      regs_q[regwr_i.idx] <= regwr_i.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_add_reg;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.op == OP_ADD && instr_i.mode == AM_REG |=> !done_o ##1 done_o;
  endproperty
  a_add_reg: assert property (p_add_reg) else $error("register add not done in one cycle");

  property p_inc_dp;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.op == OP_INC_DP |=> ##1 done_o && data_pointer_o == $past(data_pointer_o, 2) + 16'h0001;
  endproperty
  a_inc_dp: assert property (p_inc_dp) else $error("pointer increment wrong");

  property p_mul;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.op == OP_TIMES_OP |=> !done_o [*2] ##1 done_o;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply not two cycles");

  property p_div;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.op == OP_DIV |=> !done_o [*6] ##1 done_o;
  endproperty
  a_div: assert property (p_div) else $error("divide not six cycles");

  property p_swap;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.op == OP_SWAP |=> ##1 acc_o == {$past(acc_o[3:0], 2), $past(acc_o[7:4], 2)};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_xor_imm;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.op == OP_BITWISE_XOR && instr_i.mode == AM_IMM
      |=> ##2 done_o && acc_o == ($past(acc_o, 3) ^ $past(instr_i.arg1, 3));
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("immediate xor wrong");

  property p_rotl;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.op == OP_ROTATE_LEFT |=> ##1 acc_o == {$past(acc_o[6:0], 2), $past(acc_o[7], 2)};
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left wrong");

  property p_dir_addr;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.mode == AM_DIR |=> mem_addr_o == {8'h00, $past(instr_i.arg1)} && mem_space_o == SP_IRAM;
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong");

  property p_log_dir;
    @(posedge clk_sys_i) disable iff (rst_c)
    take && instr_i.op == OP_BITWISE_AND && instr_i.mode == AM_DIR_A |=> !mem_we_o ##1 !mem_we_o ##1 !mem_we_o ##1 mem_we_o;
  endproperty
  a_log_dir: assert property (p_log_dir) else $error("direct logic write timing wrong");

  property p_pin_reset;
    @(posedge clk_sys_i) disable iff (rst_i)
    !external_reset_pin_n_i |=> !busy_o && acc_o == ACC_RST;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low did not hold reset");

endmodule // mae_exec

// *** bench/mae_exec_tb.sv ***
/*
  Self-checking bench for the execution unit: walks every operation and operand mode.
  Assumes an asynchronous memory that answers on mem_rd_i for the address presented.
*/
`timescale 1ns/1ns
module testbench;
  import mae_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic        clk_sys_i              = 1'b0;
  logic        rst_i                  = 1'b1;
  logic        external_reset_pin_n_i = 1'b1;
  logic        start_i                = 1'b0;
  mae_instr_t  instr_i                = '0;
  logic [1:0]  bank_sel_i             = 2'h0;
  mae_regwr_t  regwr_i                = '0;
  logic [7:0]  mem_rd_i;
  logic [15:0] mem_addr_o;
  mae_space_t  mem_space_o;
  logic        mem_re_o;
  logic        mem_we_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  acc_o;
  logic [7:0]  b_o;
  mae_flags_t  flags_o;
  logic [15:0] data_pointer_o;
  logic        bit_o;
  logic        busy_o;
  logic        done_o;
  logic [1:0]  len_o;
  logic [7:0]  mem [256];
  logic [7:0]  reg_m [32];
  logic [7:0]  e_acc, e_b;
  logic        e_cy, e_ac, e_ov, e_bit;
  logic [15:0] e_dp;
  logic [1:0]  bank = 2'h1;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  mae_mode_t   ims [4] = '{AM_ACC, AM_REG, AM_DIR, AM_IND};
  logic [7:0]  ias [4] = '{8'h00, 8'h03, 8'h40, 8'h01};
  mae_mode_t   ams [5] = '{AM_REG, AM_DIR, AM_IND, AM_IMM, AM_IND_DP};
  logic [7:0]  aas [5] = '{8'h03, 8'h40, 8'h01, 8'ha7, 8'h00};
  mae_op_t     aops [6] = '{OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
                            OP_BITWISE_AND, OP_BITWISE_OR, OP_BITWISE_XOR};
  mae_op_t     cops [8] = '{OP_INVERT_ACC, OP_ROTATE_LEFT, OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT,
                            OP_ROTATE_RIGHT_THROUGH_CARRY, OP_SWAP, OP_ROTATE_LEFT_THROUGH_CARRY, OP_ZERO_ACC};

  // Clock at 10 MHz
  always #50 clk_sys_i = ~clk_sys_i;

  // Memory answers at once; other spaces scrambled so a wrong space shows
  assign mem_rd_i = mem[mem_addr_o[7:0]] ^ (mem_space_o == SP_XRAM ? 8'ha5 : mem_space_o == SP_CODE ? 8'h5a : 8'h00);

  mae_exec u_mae_exec (
    .clk_sys_i              (clk_sys_i),
    .rst_i                  (rst_i),
    .external_reset_pin_n_i (external_reset_pin_n_i),
    .start_i                (start_i),
    .instr_i                (instr_i),
    .bank_sel_i             (bank_sel_i),
    .regwr_i                (regwr_i),
    .mem_rd_i               (mem_rd_i),
    .mem_addr_o             (mem_addr_o),
    .mem_space_o            (mem_space_o),
    .mem_re_o               (mem_re_o),
    .mem_we_o               (mem_we_o),
    .mem_wdata_o            (mem_wdata_o),
    .acc_o                  (acc_o),
    .b_o                    (b_o),
    .flags_o                (flags_o),
    .data_pointer_o                 (data_pointer_o),
    .bit_o                  (bit_o),
    .busy_o                 (busy_o),
    .done_o                 (done_o),
    .len_o                  (len_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // Outputs idle and zero, model cleared to match
  task automatic chk_reset();
    chk(acc_o === 8'h00 && b_o === 8'h00 && flags_o === 3'h0 && data_pointer_o === 16'h0000, "reset values");
    chk(busy_o === 1'b0 && done_o === 1'b0, "reset idle");
    {e_acc, e_b, e_cy, e_ac, e_ov, e_bit, e_dp} = '0;
    foreach (reg_m[i]) reg_m[i] = 8'h00;
  endtask

  // Load one working register through the load port
  task automatic wreg(input logic [4:0] idx, input logic [7:0] d);
    @(posedge clk_sys_i);
    regwr_i <= '{1'b1, idx, d};
    @(posedge clk_sys_i);
    regwr_i <= '{1'b0, idx, d};
    reg_m[idx] = d;
  endtask

  // One instruction: predict, issue, time it and judge every output but busy_o
  task automatic run(input mae_op_t op, input mae_mode_t md, input logic [7:0] a1, input logic [7:0] a2,
                     input logic pk);
    logic [7:0]  s, o, r;
    logic [15:0] ad;
    logic [8:0]  t;
    logic [4:0]  u;
    logic [1:0]  ln;
    logic        c, we, rd;
    mae_space_t  sp;
    int          n, k;
    ad = 16'h0000;
    s = e_acc;
    we = 1'b0;
    r = 8'h00;
    n = 1;
    c = e_cy;
    case (md)
      AM_REG: s = reg_m[{bank, a1[2:0]}];
      AM_DIR, AM_DIR_A, AM_DIR_IMM: ad = {8'h00, a1};
      AM_IND: ad = {8'h00, reg_m[{bank, 2'h0, a1[0]}]};
      AM_IMM: s = a1;
      AM_IND_DP: ad = e_dp;
      AM_IDX: ad = e_dp + {8'h00, e_acc};
      AM_BIT: ad = {8'h00, a1[7] ? (a1 & 8'hf8) : (8'h20 + {4'h0, a1[6:3]})};
      default: ;
    endcase
    rd = md inside {AM_DIR, AM_IND, AM_DIR_A, AM_DIR_IMM, AM_IND_DP, AM_IDX, AM_BIT};
    sp = (md == AM_IND_DP) ? SP_XRAM : (md == AM_IDX) ? SP_CODE : SP_IRAM;
    if (rd) s = mem[ad[7:0]] ^ (md == AM_IND_DP ? 8'ha5 : md == AM_IDX ? 8'h5a : 8'h00);
    ln = (md inside {AM_DIR, AM_IMM, AM_DIR_A, AM_BIT}) ? 2'h2 : (md == AM_DIR_IMM) ? 2'h3 : 2'h1;
    case (op)
      OP_ADD, OP_ADD_WITH_CARRY: begin
        c = c & (op == OP_ADD_WITH_CARRY);
        t = {1'b0, e_acc} + {1'b0, s} + {8'h00, c};
        u = {1'b0, e_acc[3:0]} + {1'b0, s[3:0]} + {4'h0, c};
        {e_cy, e_ac, e_ov} = {t[8], u[4], (e_acc[7] == s[7]) && (t[7] != e_acc[7])};
        e_acc = t[7:0];
      end
      OP_SUBTRACT_WITH_BORROW: begin
        t = {1'b0, e_acc} - {1'b0, s} - {8'h00, c};
        u = {1'b0, e_acc[3:0]} - {1'b0, s[3:0]} - {4'h0, c};
        {e_cy, e_ac, e_ov} = {t[8], u[4], (e_acc[7] != s[7]) && (t[7] != e_acc[7])};
        e_acc = t[7:0];
      end
      OP_BITWISE_AND, OP_BITWISE_OR, OP_BITWISE_XOR: begin
        o = (md == AM_DIR_IMM) ? a2 : e_acc;
        r = (op == OP_BITWISE_AND) ? (s & o) : (op == OP_BITWISE_OR) ? (s | o) : (s ^ o);
        we = md inside {AM_DIR_A, AM_DIR_IMM};
        if (!we) e_acc = r;
      end
      OP_INC, OP_STEP_DOWN: begin
        r = (op == OP_INC) ? s + 8'h01 : s - 8'h01;
        n = (md == AM_ACC) ? 1 : (md == AM_REG) ? 2 : 3;
        we = md inside {AM_DIR, AM_IND};
        if (md == AM_ACC) e_acc = r;
        if (md == AM_REG) reg_m[{bank, a1[2:0]}] = r;
      end
      OP_INC_DP: e_dp = e_dp + 16'h0001;
      OP_TIMES_OP: begin
        n = 2;
        {e_b, e_acc} = e_acc * e_b;
        {e_cy, e_ov} = {1'b0, e_b != 8'h00};
      end
      OP_DIV: begin
        n = 6;
        {e_cy, e_ov} = {1'b0, e_b == 8'h00};
        if (!e_ov) {e_acc, e_b} = {e_acc / e_b, e_acc % e_b};
      end
      OP_DECIMAL_ADJUST: begin
        n = 3;
        t = {1'b0, e_acc};
        if (t[3:0] > 4'h9 || e_ac) t = t + 9'h006;
        if (t[7:4] > 4'h9 || e_cy || t[8]) t = t + 9'h060;
        e_cy = e_cy | t[8];
        e_acc = t[7:0];
      end
      OP_ZERO_ACC: e_acc = 8'h00;
      OP_INVERT_ACC: e_acc = ~e_acc;
      OP_ROTATE_LEFT: e_acc = {e_acc[6:0], e_acc[7]};
      OP_ROTATE_LEFT_THROUGH_CARRY: {e_cy, e_acc} = {e_acc, e_cy};
      OP_ROTATE_RIGHT: e_acc = {e_acc[0], e_acc[7:1]};
      OP_ROTATE_RIGHT_THROUGH_CARRY: {e_acc, e_cy} = {e_cy, e_acc};
      OP_SWAP: e_acc = {e_acc[3:0], e_acc[7:4]};
      OP_CODE_RD: n = 5;
      OP_BIT_RD: n = 2;
      default: ;
    endcase
    if (op == OP_CODE_RD) e_acc = s;
    if (op == OP_BIT_RD) e_bit = s[a1[2:0]];
    if (op inside {aops}) n = (md == AM_REG) ? 1 : we ? 3 : 2;
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    instr_i <= '{op, md, a1[2:0], a1, a2};
    bank_sel_i <= bank;
    @(posedge clk_sys_i);
    start_i <= pk;
    instr_i.op <= OP_ZERO_ACC;
    #1;
    if (rd) chk(mem_re_o === 1'b1 && mem_addr_o === ad && mem_space_o === sp, "operand address");
    k = 0;
    while (done_o !== 1'b1 && k < 12) begin
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      #1;
      k++;
    end
    chk(k == n && len_o === ln, "cycle count or length");
    chk(mem_we_o === we && (!we || (mem_wdata_o === r && mem_addr_o === ad)), "byte write");
    if (mem_we_o === 1'b1) mem[mem_addr_o[7:0]] = mem_wdata_o;
    chk(acc_o === e_acc && b_o === e_b && data_pointer_o === e_dp && bit_o === e_bit, "results");
    chk(flags_o === {e_cy, e_ac, e_ov}, "flags");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] * 8'h07 + 8'h03;
    mem[8'h23] = 8'h08;
    mem[8'h88] = 8'hf7;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1;
    chk_reset();
    wreg(5'h0b, 8'h37);
    wreg(5'h09, 8'h41);
    for (int i = 0; i < 8; i++) run(i[2] ? OP_STEP_DOWN : OP_INC, ims[i % 4], ias[i % 4], 8'h00, 1'b0);
    run(OP_INC_DP, AM_ACC, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 30; i++) run(aops[i / 5], ams[i % 5], aas[i % 5], 8'h00, 1'b0);
    for (int i = 3; i < 6; i++) begin
      run(aops[i], AM_DIR_A, 8'h42, 8'h00, 1'b0);
      run(aops[i], AM_DIR_IMM, 8'h43, 8'h5e, 1'b0);
    end
    run(OP_ADD, AM_IMM, 8'hb6, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++) run(cops[i], AM_ACC, 8'h00, 8'h00, 1'b0);
    run(OP_ADD, AM_IMM, 8'h38, 8'h00, 1'b0);
    run(OP_ADD, AM_IMM, 8'h49, 8'h00, 1'b0);
    run(OP_DECIMAL_ADJUST, AM_ACC, 8'h00, 8'h00, 1'b0);
    run(OP_ADD, AM_IMM, 8'h99, 8'h00, 1'b0);
    run(OP_DECIMAL_ADJUST, AM_ACC, 8'h00, 8'h00, 1'b0);
    run(OP_TIMES_OP, AM_ACC, 8'h00, 8'h00, 1'b0);
    run(OP_ADD, AM_IMM, 8'h6d, 8'h00, 1'b0);
    run(OP_DIV, AM_ACC, 8'h00, 8'h00, 1'b1);
    run(OP_CODE_RD, AM_IDX, 8'h00, 8'h00, 1'b0);
    run(OP_BIT_RD, AM_BIT, 8'h1b, 8'h00, 1'b0);
    run(OP_BIT_RD, AM_BIT, 8'h8b, 8'h00, 1'b0);
    // Pin-driven reset in mid-run, then registers must read back as zero
    @(posedge clk_sys_i);
    external_reset_pin_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    external_reset_pin_n_i <= 1'b1;
    #1;
    chk_reset();
    run(OP_ADD, AM_REG, 8'h03, 8'h00, 1'b0);
    test_done();
  end

endmodule  // testbench
